/* File: inc/acs_pkg.sv */
// acs_pkg: constants and types shared by the conversion sequencer files
// assumes a 100 MHz system clock and an 8-bit successive-approximation core

package acs_pkg;

  // register indices on the plain register port
  localparam logic [3:0] ACS_CTRL_IDX   = 4'h0;
  localparam logic [3:0] ACS_STATUS_IDX = 4'h1;
  localparam logic [3:0] ACS_RESULT_IDX = 4'h2;

  // control register field positions
  localparam int ACS_CTRL_START_BIT  = 0;
  localparam int ACS_CTRL_CONT_BIT   = 1;
  localparam int ACS_CTRL_HWSEL_BIT  = 2;
  localparam int ACS_CTRL_CH_LSB     = 4;

  // status and result field positions
  localparam int ACS_STATUS_BUSY_BIT = 0;
  localparam int ACS_RESULT_CH_LSB   = 8;

  // values after reset
  localparam logic       ACS_CONT_RST  = 1'b0;
  localparam logic       ACS_HWSEL_RST = 1'b0;
  localparam logic [2:0] ACS_CH_RST    = 3'h0;

  // counts of cycles
  localparam int ACS_IRQ_CYCLES    = 2;
  localparam int ACS_SAMPLE_CYCLES = 4;

  // sequencer states, gray along idle, sample, convert
  typedef enum logic [1:0] {
    ACS_IDLE    = 2'b00,
    ACS_SAMPLE  = 2'b01,
    ACS_CONVERT = 2'b11
  } acs_state_e;

endpackage

/* File: rtl/acs_sar_core.sv */
// acs_sar_core: successive-approximation bit search, one bit per cycle
// assumes a comparator input from the analog side, same clock domain

module acs_sar_core
  import acs_pkg::*;
#(
  parameter int RES_BITS = 8
) (
  input  wire logic                clk,       // system clock
  input  wire logic                rst_n,     // async reset, active low
  input  wire logic                go,        // one-cycle start pulse
  input  wire logic                cmp_in,    // comparator: input above trial
  output logic [RES_BITS-1:0]      trial,     // trial code to the dac
  output logic                     done,      // one-cycle finish pulse
  output logic [RES_BITS-1:0]      result     // final code
);

  typedef struct packed {
    logic                run;
    logic [RES_BITS-1:0] code;
    logic [RES_BITS-1:0] mask;
    logic                done;
  } acs_sar_s;

  acs_sar_s st_reg;
  acs_sar_s st_next;

  ////////////////////////////////////////////////////////////////////////////
  // keep or drop the trial bit, then move to the next lower one
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (go) begin
      st_next.run  = 1'b1;
      st_next.mask = {1'b1, {(RES_BITS-1){1'b0}}};
      st_next.code = {1'b1, {(RES_BITS-1){1'b0}}};
    end else if (st_reg.run) begin
      if (!cmp_in) begin
        st_next.code = st_reg.code & ~st_reg.mask;
      end
      st_next.mask = st_reg.mask >> 1;
      st_next.code = st_next.code | (st_reg.mask >> 1);
      if (st_reg.mask[0]) begin
        st_next.run  = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign trial  = st_reg.code;
  assign done   = st_reg.done;
  assign result = st_reg.code;

endmodule

/* File: rtl/acs_sequencer.sv */
// acs_sequencer: start, mode and result logic of the 8-bit converter
// assumes software on a plain register port and a trigger from the
// capture/compare unit on the same clock; the comparator arrives from
// the analog side and is synchronised here
//
// Function
// [R1] source bit 0: software start only
// [R2] writing start 1 converts selected channel
// [R3] continuous mode bit resets to 0
// [R4] start: sample, set busy, clear start
// [R5] done interrupt high exactly two clocks
// [R6] result register gets code and channel
// [R7] continuous mode restarts after each conversion
// [R8] continuous: start cleared at first conversion
// [R9] continuous: busy held until last completes
// [R10] continuous: interrupt after every conversion
// [R11] software clears continuous bit to stop
// [R12] channel change applies to following conversions
// [R13] new start only after conversion completes
// [R14] source bit 1: trigger starts conversions
// [R15] software lets conversion finish before switching
// [R16] five multiplexed channels, also digital inputs
// [R17] trigger starts like software, dropped while busy

module acs_sequencer
  import acs_pkg::*;
#(
  parameter int NUM_CH   = 5,
  parameter int RES_BITS = 8
) (
  input  wire logic                clk,          // system clock, 100 MHz
  input  wire logic                rst_n,        // async reset, active low
  input  wire logic [3:0]          reg_addr,     // register index
  input  wire logic [15:0]         reg_wdata,    // write data
  input  wire logic                reg_wr,       // write strobe
  input  wire logic                reg_rd,       // read strobe
  output logic [15:0]              reg_rdata,    // read data, cycle after
  input  wire logic                secondary_timer_period_match, // hw trigger
  input  wire logic                cmp_in,       // comparator pin
  input  wire logic [NUM_CH-1:0]   ain_digital,  // channel pins as digital
  output logic [2:0]               mux_sel,      // analog mux select
  output logic                     sample_en,    // sample switch closed
  output logic [RES_BITS-1:0]      dac_code,     // trial code
  output logic                     converter_busy_flag, // busy
  output logic                     conversion_done_irq  // done pulse
);

  typedef struct packed {
    acs_state_e          state;
    logic                software_start_bit;
    logic                continuous_mode_bit;
    logic                hw_trigger_source_select;
    logic [2:0]          channel_select_field;
    logic [2:0]          conv_ch;
    logic [2:0]          smp_cnt;
    logic [1:0]          irq_cnt;
    logic [RES_BITS-1:0] res_code;
    logic [2:0]          res_ch;
    logic [15:0]         rdata;
    logic                busy;
    logic                irq;
    logic                go;
    logic [2:0]          cmp_sync;
    logic                cmp_q;
    logic [NUM_CH-1:0]   din_s1;
    logic [NUM_CH-1:0]   din_s2;
    logic [NUM_CH-1:0]   din_s3;
    logic [NUM_CH-1:0]   din_q;
  } acs_seq_s;

  acs_seq_s st_reg;
  acs_seq_s st_next;

  logic                sar_done;
  logic [RES_BITS-1:0] sar_result;
  logic [RES_BITS-1:0] sar_trial;

  // channel field clipped to the implemented channel count
  function automatic logic [2:0] acs_clip_ch(input logic [2:0] ch);
    if (ch >= 3'(NUM_CH)) begin
      return 3'(NUM_CH - 1);
    end
    return ch;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bit search engine, fed by the filtered comparator
  acs_sar_core #(
    .RES_BITS (RES_BITS)
  ) u_sar (
    .clk    (clk),
    .rst_n  (rst_n),
    .go     (st_reg.go),
    .cmp_in (st_reg.cmp_q),
    .trial  (sar_trial),
    .done   (sar_done),
    .result (sar_result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole block
  always_comb begin
    logic start_req;
    logic hw_start;
    logic sw_start;
    start_req = 1'b0;
    hw_start  = 1'b0;
    sw_start  = 1'b0;
    st_next   = st_reg;
    st_next.go = 1'b0;

    // three-stage pin synchronisers; change counts when stages 2 and 3 agree
    st_next.cmp_sync = {st_reg.cmp_sync[1:0], cmp_in};
    if (st_reg.cmp_sync[1] == st_reg.cmp_sync[2]) begin
      st_next.cmp_q = st_reg.cmp_sync[2];
    end
    st_next.din_s1 = ain_digital;
    st_next.din_s2 = st_reg.din_s1;
    st_next.din_s3 = st_reg.din_s2;
    for (int i = 0; i < NUM_CH; i++) begin
      if (st_reg.din_s2[i] == st_reg.din_s3[i]) begin
        st_next.din_q[i] = st_reg.din_s3[i];                     // [R16]
      end
    end

    // register writes
    if (reg_wr) begin
      if (reg_addr == ACS_CTRL_IDX) begin
        if (reg_wdata[ACS_CTRL_START_BIT]) begin
          st_next.software_start_bit = 1'b1;                       // [R2]
        end
        st_next.continuous_mode_bit      = reg_wdata[ACS_CTRL_CONT_BIT]; // [R11]
        st_next.hw_trigger_source_select = reg_wdata[ACS_CTRL_HWSEL_BIT];
        st_next.channel_select_field     =
          acs_clip_ch(reg_wdata[ACS_CTRL_CH_LSB +: 3]);            // [R12]
      end
    end

    // start sources; the trigger is a same-clock logic signal
    sw_start = st_reg.software_start_bit && !st_reg.hw_trigger_source_select; // [R1]
    hw_start = secondary_timer_period_match && st_reg.hw_trigger_source_select; // [R14]

    // done interrupt countdown
    if (st_reg.irq_cnt != 2'd0) begin
      st_next.irq_cnt = st_reg.irq_cnt - 2'd1;
    end

    case (st_reg.state)
      ACS_IDLE: begin
        // a trigger seen while not idle is simply not looked at
        start_req = sw_start || hw_start;                          // [R13] [R17]
      end
      ACS_SAMPLE: begin
        if (st_reg.smp_cnt == 3'(ACS_SAMPLE_CYCLES - 1)) begin
          st_next.state = ACS_CONVERT;
          st_next.go    = 1'b1;
        end else begin
          st_next.smp_cnt = st_reg.smp_cnt + 3'd1;
        end
      end
      ACS_CONVERT: begin
        if (sar_done) begin
          st_next.res_code = sar_result;                           // [R6]
          st_next.res_ch   = st_reg.conv_ch;                       // [R6]
          st_next.irq_cnt  = 2'(ACS_IRQ_CYCLES);                   // [R5] [R10]
          if (st_reg.continuous_mode_bit) begin
            // back-to-back: busy never drops between conversions
            st_next.state   = ACS_SAMPLE;                          // [R7] [R9]
            st_next.smp_cnt = 3'd0;
            st_next.conv_ch = st_reg.channel_select_field;         // [R12]
          end else begin
            st_next.state = ACS_IDLE;
            st_next.busy  = 1'b0;                                  // [R9]
          end
        end
      end
      default: begin
        st_next.state = ACS_IDLE;
      end
    endcase

    if (start_req) begin
      st_next.state   = ACS_SAMPLE;                                // [R4]
      st_next.smp_cnt = 3'd0;
      st_next.conv_ch = st_reg.channel_select_field;               // [R2]
      st_next.busy    = 1'b1;                                      // [R4]
      // start bit cleared at the first conversion of any sequence
      st_next.software_start_bit = 1'b0;                           // [R4] [R8]
    end

    st_next.irq = (st_next.irq_cnt != 2'd0);                       // [R5]

    // read data, valid the cycle after the strobe only
    st_next.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == ACS_CTRL_IDX) begin
        st_next.rdata[ACS_CTRL_START_BIT]      = st_reg.software_start_bit;
        st_next.rdata[ACS_CTRL_CONT_BIT]       = st_reg.continuous_mode_bit;
        st_next.rdata[ACS_CTRL_HWSEL_BIT]      = st_reg.hw_trigger_source_select;
        st_next.rdata[ACS_CTRL_CH_LSB +: 3]    = st_reg.channel_select_field;
      end else if (reg_addr == ACS_STATUS_IDX) begin
        st_next.rdata[ACS_STATUS_BUSY_BIT]     = st_reg.busy;
        st_next.rdata[ACS_RESULT_CH_LSB +: NUM_CH] = st_reg.din_q;
      end else if (reg_addr == ACS_RESULT_IDX) begin
        st_next.rdata[RES_BITS-1:0]            = st_reg.res_code;
        st_next.rdata[ACS_RESULT_CH_LSB +: 3]  = st_reg.res_ch;
      end else begin
        st_next.rdata = '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; continuous mode comes out of reset as single
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg                          <= '0;
      st_reg.state                    <= ACS_IDLE;
      st_reg.continuous_mode_bit      <= ACS_CONT_RST;           // [R3]
      st_reg.hw_trigger_source_select <= ACS_HWSEL_RST;
      st_reg.channel_select_field     <= ACS_CH_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // dac code goes through its own flop; every output but sample_en comes from a flop
  logic [RES_BITS-1:0] dac_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_reg <= '0;
    end else begin
      dac_reg <= sar_trial;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops, except sample_en, which is decoded from the state register
  assign reg_rdata           = st_reg.rdata;
  assign mux_sel             = st_reg.conv_ch;
  assign sample_en           = (st_reg.state == ACS_SAMPLE);
  assign dac_code            = dac_reg;
  assign converter_busy_flag = st_reg.busy;
  assign conversion_done_irq = st_reg.irq;

endmodule

/* File: test/acs_sequencer_checker.sv */
// acs_sequencer_checker: timing checks on the sequencer's outputs
// assumes one clock domain; attached to every acs_sequencer by bind
module acs_sequencer_checker (
  input wire logic       clk,                 // system clock
  input wire logic       rst_n,               // async reset, active low
  input wire logic [2:0] mux_sel,             // channel converted
  input wire logic       sample_en,           // sample phase
  input wire logic       converter_busy_flag, // busy
  input wire logic       conversion_done_irq  // done pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // multi-step shapes of the pulses
  sequence irq_pair_s;
    conversion_done_irq [*2] ##1 !conversion_done_irq;
  endsequence
  sequence sample_win_s;
    sample_en [*4] ##1 !sample_en;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  irq_two_cycles_a: assert property ($rose(conversion_done_irq) |-> irq_pair_s)
    else $error("done pulse not two cycles long");
  sample_window_a: assert property ($rose(sample_en) |-> sample_win_s)
    else $error("sample phase not four cycles long");
  busy_samples_a: assert property ($rose(converter_busy_flag) |-> sample_en)
    else $error("busy rose without sampling");
  conv_bounded_a: assert property ($rose(converter_busy_flag) |-> ##[8:30] $rose(conversion_done_irq))
    else $error("conversion did not finish in time");
  mux_hold_a: assert property (sample_en && $past(sample_en) |-> $stable(mux_sel))
    else $error("channel moved while sampling");
  mux_range_a: assert property (converter_busy_flag |-> mux_sel <= 3'h4)
    else $error("channel beyond the fifth");
  sample_busy_a: assert property (sample_en |-> converter_busy_flag)
    else $error("sampling while not busy");
  irq_busy_a: assert property ($rose(conversion_done_irq) |-> $past(converter_busy_flag))
    else $error("done pulse without a conversion");
endmodule

bind acs_sequencer acs_sequencer_checker chk_i (.clk, .rst_n, .mux_sel, .sample_en,
  .converter_busy_flag, .conversion_done_irq);

/* File: test/acs_sequencer_test.sv */
// acs_sequencer_test: random and corner runs of the conversion sequencer
// assumes a constant comparator, so codes come out all ones or all zeros
module acs_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, cmp_in = 0, trig_en = 0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [4:0]  ain_digital = 5'h00;
  logic [2:0]  mux_sel, ch;
  logic [7:0]  dac_code;
  logic        sample_en, busy, irq, trig;
  logic [31:0] rnd = 32'h81a2_1723;
  int          n_fail = 0, checks_done = 0, n_idle = 0, n_irq = 0, hi;
  always #5 clk = ~clk;
  acs_sequencer uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .secondary_timer_period_match(trig), .cmp_in, .ain_digital, .mux_sel, .sample_en,
    .dac_code, .converter_busy_flag(busy), .conversion_done_irq(irq));
  acs_trigger_model tmod (.clk, .rst_n, .enable(trig_en), .period_match(trig));
  // idle and done-pulse cycles, sampled away from the edge
  always @(negedge clk) begin
    n_idle += (busy !== 1'b1);
    n_irq  += (irq === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_res(input logic [2:0] c, input logic v);
    return {5'h00, c, v ? 8'hff : 8'h00};
  endfunction
  task automatic complete_run;
    $display("checks_done %0d n_fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hang;
    n_fail++;
    complete_run();
  endtask
  // bus cycles start on an edge; read data are looked at mid-cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask
  task automatic wait_busy(input logic v);
    for (int i = 0; i < 200; i++) begin
      @(negedge clk);
      if (busy === v) return;
    end
    hang();
  endtask
  task automatic wait_irq(output int h);
    h = 0;
    for (int i = 0; i < 200 && h == 0; i++) begin
      @(negedge clk);
      while (irq === 1'b1 && h < 9) begin
        h++;
        @(negedge clk);
      end
    end
    if (h == 0) hang();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(ACS_CTRL_IDX, 16'h0000);
    // triggers ignored while software owns the start
    @(posedge clk);
    trig_en <= 1'b1;
    n_idle = 0;
    repeat (20) @(posedge clk);
    trig_en <= 1'b0;
    chk(16'(n_idle), 16'd20);
    // single runs over all channel codes, clamp included
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      ch  = (k > 4) ? 3'h4 : 3'(k);
      @(posedge clk);
      cmp_in      <= rnd[0];
      ain_digital <= rnd[12:8];
      wr(ACS_CTRL_IDX, 16'h0001 | 16'(k << 4));
      wait_busy(1'b1);
      chk(16'(mux_sel), 16'(ch));
      rd(ACS_CTRL_IDX, 16'(ch) << 4);
      wait_irq(hi);
      chk(16'(hi), 16'd2);
      rd(ACS_RESULT_IDX, exp_res(ch, rnd[0]));
      chk(16'(dac_code), {8'h00, rnd[0] ? 8'hff : 8'h00});
      rd(ACS_STATUS_IDX, {3'h0, rnd[12:8], 8'h00});
    end
    // hardware start, second pulse lands while busy
    wr(ACS_CTRL_IDX, 16'h0024);
    @(posedge clk);
    trig_en <= 1'b1;
    n_irq = 0;
    wait_busy(1'b1);
    chk(16'(mux_sel), 16'h0002);
    // long enough for a second pulse while busy, too short for a third
    repeat (8) @(posedge clk);
    trig_en <= 1'b0;
    repeat (50) @(posedge clk);
    chk(16'(n_irq), 16'd2);
    // continuous run, channel change, then stop
    wr(ACS_CTRL_IDX, 16'h0013);
    wait_busy(1'b1);
    rd(ACS_CTRL_IDX, 16'h0012);
    n_idle = 0;
    repeat (3) wait_irq(hi);
    chk(16'(hi), 16'd2);
    wr(ACS_CTRL_IDX, 16'h0032);
    wait_irq(hi);
    wait_irq(hi);
    chk(16'(mux_sel), 16'h0003);
    rd(ACS_RESULT_IDX, exp_res(3'h3, cmp_in));
    @(posedge clk);
    chk(16'(n_idle), 16'd0);
    wr(ACS_CTRL_IDX, 16'h0030);
    wait_irq(hi);
    wait_busy(1'b0);
    n_idle = 0;
    repeat (30) @(posedge clk);
    chk(16'(n_idle), 16'd30);
    rd(4'hf, 16'h0000);
    complete_run();
  end
endmodule

/* File: test/acs_trigger_model.sv */
// acs_trigger_model: stand-in for the capture/compare period-match output
// assumes the sequencer clock; one-cycle pulse every PERIOD cycles while on
module acs_trigger_model #(
  parameter int PERIOD = 6
) (
  input  wire logic clk,          // system clock
  input  wire logic rst_n,        // async reset, active low
  input  wire logic enable,       // bench runs the timer
  output logic      period_match  // one-cycle trigger pulse
);
  int cnt;
  // counts only while enabled, so a short enable gives a known pulse count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt          <= 0;
      period_match <= 1'b0;
    end else begin
      period_match <= enable && cnt == 0;
      cnt          <= enable ? (cnt + 1) % PERIOD : 0;
    end
  end
endmodule
